//--- hdl/time_gate_map.svh
/*
  Holds the named constants of the time-gate controller: mode and edge
  encodings, widths, and timing figures.
  Assumes it is included by bare name before any module that uses it.
*/
`ifndef TIME_GATE_MAP_SVH
`define TIME_GATE_MAP_SVH

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define TG_TRIG_EDGE        1'h0
`define TG_TRIG_LEVEL       1'h1
`define TG_EDGE_RISE        1'h0
`define TG_EDGE_FALL        1'h1
`define TG_POL_POS          1'h0
`define TG_POL_NEG          1'h1
`define TG_APPLY_OSC        2'h0
`define TG_APPLY_VIDEO      2'h1
`define TG_APPLY_CAPTURE    2'h2

// ----------------------------------------------------------------------
// Widths and defaults
// ----------------------------------------------------------------------
`define TG_CNT_W            32
`define TG_VID_W            16
`define TG_RBW_W            4
`define TG_CAP_BASE_NS      2000
`define TG_CLK_NS           20
`define TG_CAP_BASE_CYC     ((`TG_CAP_BASE_NS + `TG_CLK_NS - 1) / `TG_CLK_NS)

`endif

//--- hdl/time_gate_pkg.sv
/*
  Types shared by the time-gate controller files.
  Assumes time_gate_map.svh is visible to the compilation unit.
*/
`default_nettype none
package time_gate_pkg;
  typedef enum logic [1:0] {APPLY_OSC, APPLY_VIDEO, APPLY_CAPTURE, APPLY_RSVD} apply_mode_e;
endpackage
`default_nettype wire

//--- hdl/gate_span_if.sv
/*
  Carries a start strobe and a cycle count to the span counter, and its
  busy and done indications back.
  Assumes one clock domain shared by both ends.
*/
`default_nettype none
interface gate_span_if #(parameter int CNT_W = 32);
  logic             start;
  logic [CNT_W-1:0] count;
  logic             busy;
  logic             done;
  modport ctrl (output start, output count, input busy, input done);
  modport cnt  (input start, input count, output busy, output done);
endinterface
`default_nettype wire

//--- hdl/gate_span_counter.sv
/*
  Counts a programmed number of clock cycles from a start strobe, the
  start cycle counted as the first, and pulses done on the last one.
  Assumes start is only given while not busy.
*/
`include "time_gate_map.svh"
`default_nettype none
module gate_span_counter #(
  parameter int CNT_W = `TG_CNT_W
) (
  // Clock and reset
  input  wire logic    I_MCLK,
  input  wire logic    I_ARST_N,
  // Control side
  gate_span_if.cnt     span
);
  logic [CNT_W-1:0] remain;

  initial begin
    if (CNT_W < 2) $error("gate_span_counter: CNT_W too small");
  end

  // Down-counter; a zero count finishes on the start cycle itself
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      remain    <= '0;
      span.busy <= 1'b0;
    end else if (span.start && span.count > CNT_W'(1)) begin
      remain    <= span.count - CNT_W'(1);
      span.busy <= 1'b1;
    end else if (span.busy && remain == CNT_W'(1)) begin
      span.busy <= 1'b0;
    end else if (span.busy) begin
      remain <= remain - CNT_W'(1);
    end
  end

  // Done pulses in the last counted cycle
  assign span.done = (span.start && span.count <= CNT_W'(1))
                   || (span.busy && remain == CNT_W'(1));
endmodule // gate_span_counter
`default_nettype wire

//--- hdl/time_gate_ctrl.sv
/*
  Time-gate controller: opens a measurement window from an external
  trigger, edge or level driven, and applies it to the oscillator sweep,
  the video path or a triggered capture.
  Assumes one 50 MHz clock, asynchronous active-low reset, and a trigger
  pin from outside the clock domain.
*/
// Function
// - Edge mode triggers on rising or falling trigger edge as selected.
// - After a trigger, wait the programmed delay, then open the gate; capture mode opens without the delay.
// - Gate stays open exactly the programmed length, or the RBW-set length in capture mode, then closes.
// - Delay and length are separate programmable settings for edge mode.
// - Level mode opens gate while trigger matches selected polarity.
// - Level mode ignores delay and length; gate follows trigger.
// - Gate-status output is low when closed and high when open.
// - Oscillator gating advances the sweep only while gate is open.
// - Video gating sweeps continuously; gate only passes or blocks video.
// - Video switch sits between envelope detector and video filter.
// - Capture gating starts capture on trigger; length follows RBW.
`include "time_gate_map.svh"
`default_nettype none
module time_gate_ctrl
  import time_gate_pkg::*;
#(
  parameter int CNT_W = `TG_CNT_W,
  parameter int VID_W = `TG_VID_W,
  parameter int RBW_W = `TG_RBW_W
) (
  // Clock and reset
  input  wire logic                I_MCLK,
  input  wire logic                I_ARST_N,
  // Trigger pin
  input  wire logic                I_TRIG,
  // Configuration
  input  wire logic                I_TRIG_MODE,
  input  wire logic                I_EDGE_SEL,
  input  wire logic                I_LEVEL_POL,
  input  wire time_gate_pkg::apply_mode_e I_APPLY_MODE,
  input  wire logic [CNT_W-1:0]    I_GATE_DELAY,
  input  wire logic [CNT_W-1:0]    I_GATE_LENGTH,
  input  wire logic [RBW_W-1:0]    I_RBW_SEL,
  // Video path, envelope detector in
  input  wire logic [VID_W-1:0]    I_ENV_DATA,
  // Gate status and applied controls
  output logic                     O_GATE,
  output logic                     O_SWEEP_ADV,
  output logic [VID_W-1:0]         O_VIDEO_DATA,
  output logic                     O_CAPTURE_ACT,
  output logic                     O_CAPTURE_START
);
  import time_gate_pkg::*;

  // --------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------
  initial begin
    if (CNT_W < 8 || CNT_W > 32) $error("time_gate_ctrl: CNT_W out of range");
    if (VID_W < 1) $error("time_gate_ctrl: VID_W must be positive");
    if (RBW_W < 1 || RBW_W > 5) $error("time_gate_ctrl: RBW_W out of range");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_OPEN} gate_state_e;

  gate_state_e      state;
  gate_state_e      next_state;
  logic             trig_meta;
  logic             trig_sync;
  logic             trig_prev;
  logic             trig_event;
  logic             level_open;
  logic             edge_open;
  logic             gate_now;
  logic [CNT_W-1:0] capture_len;
  logic [CNT_W-1:0] open_len;
  logic             capture_mode;

  gate_span_if #(.CNT_W(CNT_W)) span ();

  gate_span_counter #(.CNT_W(CNT_W)) u_span (
    .I_MCLK   (I_MCLK),
    .I_ARST_N (I_ARST_N),
    .span     (span)
  );

  // --------------------------------------------------------------------
  // Trigger input
  // --------------------------------------------------------------------
  // Two-stage synchroniser; only the second stage is looked at
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
    end else begin
      trig_meta <= I_TRIG;
      trig_sync <= trig_meta;
    end
  end

  // Previous synced level for edge detection
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_sync;
    end
  end

  // Selected edge forms the trigger event; the source is assumed periodic
  assign trig_event = (I_EDGE_SEL == `TG_EDGE_RISE) ? (trig_sync && !trig_prev)
                                                    : (!trig_sync && trig_prev);

  // Level mode follows the synchronised pin, no delay or length used
  assign level_open = (I_LEVEL_POL == `TG_POL_POS) ? trig_sync : !trig_sync;

  // --------------------------------------------------------------------
  // Window length
  // --------------------------------------------------------------------
  // Capture length scales with RBW setting: a narrower filter needs a
  // longer record, so each step of the selector doubles it
  assign capture_len = CNT_W'(`TG_CAP_BASE_CYC) << I_RBW_SEL;
  assign capture_mode = (I_APPLY_MODE == APPLY_CAPTURE);
  // Capture mode ignores the programmed length
  assign open_len = capture_mode ? capture_len : I_GATE_LENGTH;

  // --------------------------------------------------------------------
  // Edge-mode sequencer
  // --------------------------------------------------------------------
  // Next state; triggers outside idle are dropped
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (I_TRIG_MODE == `TG_TRIG_EDGE && trig_event) begin
          if (capture_mode || I_GATE_DELAY == '0) begin
            next_state = (open_len == '0) ? ST_IDLE : ST_OPEN;
          end else begin
            next_state = ST_DELAY;
          end
        end
      end
      ST_DELAY: begin
        if (span.done) begin
          next_state = (open_len == '0) ? ST_IDLE : ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (span.done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (I_TRIG_MODE == `TG_TRIG_LEVEL) begin
      next_state = ST_IDLE;
    end
  end

  // State register; reset closes the gate
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Span counter start: each phase loads its count in its own first cycle,
  // so a phase lasts exactly its count, and a count of one cannot finish
  // before its phase is entered
  always_comb begin
    span.start = 1'b0;
    span.count = '0;
    if (state == ST_DELAY && !span.busy) begin
      span.start = 1'b1;
      span.count = I_GATE_DELAY;
    end else if (state == ST_OPEN && !span.busy) begin
      span.start = 1'b1;
      span.count = open_len;
    end
  end

  assign edge_open = (next_state == ST_OPEN);
  assign gate_now  = (I_TRIG_MODE == `TG_TRIG_LEVEL) ? level_open : edge_open;

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Gate status, high while open
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_GATE <= 1'b0;
    end else begin
      O_GATE <= gate_now;
    end
  end

  // Sweep advance: gated only in oscillator mode; video mode never stops
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_SWEEP_ADV <= 1'b0;
    end else begin
      unique case (I_APPLY_MODE)
        APPLY_OSC:     O_SWEEP_ADV <= gate_now;
        APPLY_VIDEO:   O_SWEEP_ADV <= 1'b1;
        APPLY_CAPTURE: O_SWEEP_ADV <= 1'b0;
        default:       O_SWEEP_ADV <= 1'b0;
      endcase
    end
  end

  // Video switch after detector, before filter; zero when blocked
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_VIDEO_DATA <= '0;
    end else if (I_APPLY_MODE != APPLY_VIDEO || gate_now) begin
      O_VIDEO_DATA <= I_ENV_DATA;
    end else begin
      O_VIDEO_DATA <= '0;
    end
  end

  // Capture strobe and active window in capture mode
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_CAPTURE_ACT   <= 1'b0;
      O_CAPTURE_START <= 1'b0;
    end else begin
      O_CAPTURE_ACT   <= capture_mode && gate_now;
      O_CAPTURE_START <= capture_mode && gate_now && !O_CAPTURE_ACT;
    end
  end
endmodule // time_gate_ctrl
`default_nettype wire

//--- dv/trig_source.sv
/* Periodic trigger source standing at the controller's trigger pin.
   Assumes the bench clock and an active-low reset. */
`default_nettype none
module trig_source (
  // Clock, reset, enable
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_en,
  // Trigger pin
  output var  logic o_trig
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] phase;
  // ------------------------------
  // Pulse train, 10 cycles, 4 high
  // ------------------------------
  // Idles low when off, so switching it in adds no stray edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase  <= 4'h0;
      o_trig <= 1'b0;
    end else begin
      phase  <= (!i_en || phase == 4'h9) ? 4'h0 : phase + 4'h1;
      o_trig <= i_en && phase < 4'h4;
    end
  end
endmodule // trig_source
`default_nettype wire

//--- dv/time_gate_checker.sv
/* Port checks for the time-gate controller, bound at the foot.
   Assumes one clock and an asynchronous active-low reset. */
`default_nettype none
module time_gate_checker
  import time_gate_pkg::*;
#(parameter int CNT_W = 32, parameter int VID_W = 16, parameter int RBW_W = 4) (
  // Clock, reset and inputs
  input wire logic                       I_MCLK,
  input wire logic                       I_ARST_N,
  input wire logic                       I_TRIG,
  input wire logic                       I_TRIG_MODE,
  input wire logic                       I_LEVEL_POL,
  input wire time_gate_pkg::apply_mode_e I_APPLY_MODE,
  input wire logic [CNT_W-1:0]           I_GATE_LENGTH,
  input wire logic [RBW_W-1:0]           I_RBW_SEL,
  input wire logic [VID_W-1:0]           I_ENV_DATA,
  // Outputs watched
  input wire logic                       O_GATE,
  input wire logic                       O_SWEEP_ADV,
  input wire logic [VID_W-1:0]           O_VIDEO_DATA,
  input wire logic                       O_CAPTURE_ACT,
  input wire logic                       O_CAPTURE_START
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0]       since;
  logic [CNT_W-1:0] open_cnt;
  logic [CNT_W-1:0] cap_cnt;
  // -------------------------
  // Window length counters
  // -------------------------
  // Counters measure each window, so lengths need no long repetition
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      since    <= 3'h0;
      open_cnt <= '0;
      cap_cnt  <= '0;
    end else begin
      since    <= (since == 3'h7) ? since : since + 3'h1;
      open_cnt <= O_GATE ? open_cnt + 1'b1 : '0;
      cap_cnt  <= O_CAPTURE_ACT ? cap_cnt + 1'b1 : '0;
    end
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_ARST_N);
  gate_len_a: assert property (
    $fell(O_GATE) && !I_TRIG_MODE && I_APPLY_MODE != APPLY_CAPTURE
    |-> open_cnt == I_GATE_LENGTH) else $error("gate open length wrong");
  cap_len_a: assert property (
    $fell(O_CAPTURE_ACT) |-> cap_cnt == (CNT_W'(32'h64) << I_RBW_SEL))
    else $error("capture length wrong");
  level_follow_a: assert property (
    since == 3'h7 && I_TRIG_MODE && $past(I_TRIG_MODE, 4) && $stable(I_LEVEL_POL)
    |-> O_GATE == ($past(I_TRIG, 3) ^ I_LEVEL_POL)) else $error("level gate wrong");
  sweep_osc_a: assert property (
    I_APPLY_MODE == APPLY_OSC && $stable(I_APPLY_MODE) |-> O_SWEEP_ADV == O_GATE)
    else $error("sweep not gated");
  sweep_video_a: assert property (
    I_APPLY_MODE == APPLY_VIDEO && $past(I_APPLY_MODE) == APPLY_VIDEO && since > 3'h1
    |-> O_SWEEP_ADV) else $error("video sweep stopped");
  video_block_a: assert property (
    I_APPLY_MODE == APPLY_VIDEO && $past(I_APPLY_MODE) == APPLY_VIDEO
    && !O_GATE && !$past(O_GATE) |-> O_VIDEO_DATA == '0)
    else $error("video not blocked");
  video_pass_a: assert property (
    I_APPLY_MODE == APPLY_VIDEO && O_GATE && $past(O_GATE)
    |-> O_VIDEO_DATA == $past(I_ENV_DATA)) else $error("video not passed");
  start_pulse_a: assert property (
    O_CAPTURE_START |-> $rose(O_CAPTURE_ACT) ##1 !O_CAPTURE_START)
    else $error("capture start not one pulse");
endmodule // time_gate_checker
bind time_gate_ctrl time_gate_checker #(.CNT_W(CNT_W), .VID_W(VID_W), .RBW_W(RBW_W)) u_chk (
  .I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_TRIG(I_TRIG), .I_TRIG_MODE(I_TRIG_MODE),
  .I_LEVEL_POL(I_LEVEL_POL), .I_APPLY_MODE(I_APPLY_MODE), .I_GATE_LENGTH(I_GATE_LENGTH),
  .I_RBW_SEL(I_RBW_SEL), .I_ENV_DATA(I_ENV_DATA), .O_GATE(O_GATE),
  .O_SWEEP_ADV(O_SWEEP_ADV), .O_VIDEO_DATA(O_VIDEO_DATA),
  .O_CAPTURE_ACT(O_CAPTURE_ACT), .O_CAPTURE_START(O_CAPTURE_START));
`default_nettype wire

//--- dv/tb_time_gate_ctrl.sv
/* Bench for the time-gate controller: edge, level, capture and reset.
   Assumes the trigger source model and the bound port checker. */
`default_nettype none
module tb_time_gate_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import time_gate_pkg::*;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        man_trig = 1'b0;
  logic        use_src = 1'b0;
  logic        trig_mode = 1'b0;
  logic        edge_sel = 1'b0;
  logic        level_pol = 1'b0;
  apply_mode_e apply_mode = APPLY_OSC;
  logic [31:0] gate_delay = 32'h5;
  logic [31:0] gate_len = 32'h7;
  logic [3:0]  rbw_sel = 4'h0;
  logic [15:0] env = 16'h0;
  logic [2:0]  hist = 3'h0;
  logic        src_trig;
  logic        gate;
  logic        sweep;
  logic        cap_act;
  logic        cap_start;
  int          miscompares = 0;
  int          n_checks = 0;
  wire         trig = use_src ? src_trig : man_trig;
  // -------------------------
  // Clock, data and instances
  // -------------------------
  initial begin
    forever #10 mclk = ~mclk;
  end
  // Envelope ramp and pin history seen at each edge
  always @(posedge mclk) begin
    env  <= env + 16'h1;
    hist <= {hist[1:0], trig};
  end
  trig_source u_src (.i_clk(mclk), .i_rst_n(arst_n), .i_en(use_src), .o_trig(src_trig));
  time_gate_ctrl u_dut (.I_MCLK(mclk), .I_ARST_N(arst_n), .I_TRIG(trig),
    .I_TRIG_MODE(trig_mode), .I_EDGE_SEL(edge_sel), .I_LEVEL_POL(level_pol),
    .I_APPLY_MODE(apply_mode), .I_GATE_DELAY(gate_delay), .I_GATE_LENGTH(gate_len),
    .I_RBW_SEL(rbw_sel), .I_ENV_DATA(env), .O_GATE(gate), .O_SWEEP_ADV(sweep),
    .O_VIDEO_DATA(), .O_CAPTURE_ACT(cap_act), .O_CAPTURE_START(cap_start));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bounded wait for the gate level; a hang ends the run
  task automatic until_gate(input logic lvl, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (gate !== lvl && n < 1000);
    if (gate !== lvl) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic quiet(input int cycles, input string what);
    int hits = 0;
    repeat (cycles) begin
      @(negedge mclk);
      hits += gate;
    end
    check(hits, 0, what);
  endtask
  // Edge trigger: delay, exact length, then a retrigger while open is dropped
  task automatic edge_test(input logic sel, input logic [31:0] d, input logic [31:0] l);
    int n;
    @(posedge mclk);
    edge_sel <= sel;
    man_trig <= sel;
    gate_delay <= d;
    gate_len <= l;
    repeat (4) @(posedge mclk);
    man_trig <= ~sel;
    until_gate(1'b1, n);
    check(n, d + 32'h4, "open delay");
    @(posedge mclk);
    man_trig <= sel;
    @(posedge mclk);
    man_trig <= ~sel;
    until_gate(1'b0, n);
    check(n + 1, l, "open length");
    quiet(d + 12, "retrigger opened gate");
    $display("edge test done");
  endtask
  // Level trigger on the periodic source, video gating
  task automatic level_test(input logic pol);
    @(posedge mclk);
    trig_mode <= 1'b1;
    level_pol <= pol;
    apply_mode <= APPLY_VIDEO;
    man_trig <= 1'b0;
    use_src <= 1'b1;
    repeat (6) @(posedge mclk);
    repeat (30) begin
      @(negedge mclk);
      check(gate, hist[2] ^ pol, "level gate");
      check(sweep, 1'b1, "video sweep");
    end
    use_src <= 1'b0;
    repeat (6) @(posedge mclk);
    $display("level test done");
  endtask
  // Triggered capture: one start, length set by the bandwidth step
  task automatic capture_test(input logic [3:0] rbw);
    int act = 0;
    int starts = 0;
    @(posedge mclk);
    trig_mode <= 1'b0;
    edge_sel <= 1'b0;
    apply_mode <= APPLY_CAPTURE;
    rbw_sel <= rbw;
    man_trig <= 1'b0;
    repeat (4) @(posedge mclk);
    man_trig <= 1'b1;
    repeat (600) begin
      @(negedge mclk);
      act += cap_act;
      starts += cap_start;
    end
    check(act, 32'h64 << rbw, "capture length");
    check(starts, 1, "capture starts");
    $display("capture test done");
  endtask
  // Reset during a pending delay closes the gate and forgets the count
  task automatic reset_test();
    @(posedge mclk);
    apply_mode <= APPLY_OSC;
    gate_delay <= 32'h14;
    man_trig <= 1'b0;
    repeat (4) @(posedge mclk);
    man_trig <= 1'b1;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b0;
    man_trig <= 1'b0;
    @(negedge mclk);
    check(gate, 1'b0, "gate in reset");
    @(posedge mclk);
    arst_n <= 1'b1;
    quiet(40, "pending delay kept");
    $display("reset test done");
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    edge_test(1'b0, 32'h5, 32'h7);
    edge_test(1'b1, 32'h1, 32'h9);
    level_test(1'b1);
    level_test(1'b0);
    for (int r = 0; r < 3; r++) capture_test(4'(r));
    reset_test();
    wrap_up();
  end
endmodule // tb_time_gate_ctrl
`default_nettype wire
